// ### rtl/mmc_cfg_if.sv
// Interface between the bus decode and the architecture bit store
`timescale 1ns/1ps
interface mmc_cfg_if;
  import mmc_pkg::*;

  logic                   wr_arch;
  logic                   wr_pol;
  logic                   wr_local;
  logic                   wr_sig;
  logic                   wr_run;
  logic [DATA_W-1:0]      wdata;
  logic                   sync_select_bit;
  logic                   global_arch_control_bit;
  mmc_cells_t             polarity;
  mmc_cells_t             local_arch_control_bit;
  logic [DATA_W-1:0]      signature;
  logic                   run;

  modport store (
    input  wr_arch, wr_pol, wr_local, wr_sig, wr_run, wdata,
    output sync_select_bit, global_arch_control_bit, polarity,
    output local_arch_control_bit, signature, run
  );
  modport user (
    output wr_arch, wr_pol, wr_local, wr_sig, wr_run, wdata,
    input  sync_select_bit, global_arch_control_bit, polarity,
    input  local_arch_control_bit, signature, run
  );
endinterface

// ### rtl/mmc_cfg_store.sv
// Architecture bit store with freeze once the logic runs
`timescale 1ns/1ps
module mmc_cfg_store (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration port
  mmc_cfg_if.store cfg
);
  import mmc_pkg::*;

  // Two global bits plus a polarity and a local bit per cell
  logic              sync_sel;
  logic              glob_ac;
  mmc_cells_t        pol;
  mmc_cells_t        local_ac;
  logic [DATA_W-1:0] sig;
  logic              run;
  logic              next_sync_sel;
  logic              next_glob_ac;
  mmc_cells_t        next_pol;
  mmc_cells_t        next_local_ac;
  logic [DATA_W-1:0] next_sig;
  logic              next_run;

  // Next values: loads only while stopped, run is set-only
  always_comb begin
    next_sync_sel = sync_sel;
    next_glob_ac  = glob_ac;
    next_pol      = pol;
    next_local_ac = local_ac;
    next_sig      = sig;
    next_run      = run;
    if (!run) begin
      if (cfg.wr_arch) begin
        next_sync_sel = cfg.wdata[ARCH_SYNC_BIT];
        next_glob_ac  = cfg.wdata[ARCH_GLOBAL_BIT];
      end
      if (cfg.wr_pol) begin
        next_pol = cfg.wdata[NUM_CELLS-1:0];
      end
      if (cfg.wr_local) begin
        next_local_ac = cfg.wdata[NUM_CELLS-1:0];
      end
      if (cfg.wr_sig) begin
        next_sig = cfg.wdata;
      end
    end
    if (cfg.wr_run) begin
      next_run = 1'h1;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_sel <= RST_SYNC;
      glob_ac  <= RST_GLOBAL;
      pol      <= RST_POL;
      local_ac <= RST_LOCAL;
      sig      <= SIG_DEFAULT;
      run      <= 1'h0;
    end else begin
      sync_sel <= next_sync_sel;
      glob_ac  <= next_glob_ac;
      pol      <= next_pol;
      local_ac <= next_local_ac;
      sig      <= next_sig;
      run      <= next_run;
    end
  end

  // Drive the stored bits out
  assign cfg.sync_select_bit         = sync_sel;
  assign cfg.global_arch_control_bit = glob_ac;
  assign cfg.polarity                = pol;
  assign cfg.local_arch_control_bit  = local_ac;
  assign cfg.signature               = sig;
  assign cfg.run                     = run;

endmodule

// ### rtl/mmc_pkg.sv
// Constants and types shared by the macrocell mode configuration block
package mmc_pkg;

  // ------------------------------------------------------------------
  // Sizes and macrocell positions
  // ------------------------------------------------------------------
  localparam int NUM_CELLS = 8;
  localparam int NUM_PINS  = NUM_CELLS + 2;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CFG_BITS  = 2 + 2 * NUM_CELLS;  // two global, 16 per-cell
  localparam int CELL_LO   = 0;                  // outermost, low side
  localparam int CELL_HI   = NUM_CELLS - 1;      // outermost, high side
  localparam int INNER_LO  = 3;                  // innermost pair
  localparam int INNER_HI  = 4;
  localparam int PIN_CLK   = NUM_CELLS;          // index in pin vector
  localparam int PIN_OE    = NUM_CELLS + 1;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ARCH    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_POL     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOCAL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SIG     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRELOAD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PINS    = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int ARCH_SYNC_BIT   = 0;
  localparam int ARCH_GLOBAL_BIT = 1;
  localparam int CTRL_RUN_BIT    = 0;
  localparam int STAT_MODE_LSB   = 0;
  localparam int STAT_RUN_BIT    = 2;
  localparam int STAT_CELLS_LSB  = 8;
  localparam int PINS_OE_LSB     = 8;
  localparam int PINS_FB_LSB     = 16;
  localparam int HTRANS_ACT_BIT  = 1;

  // ------------------------------------------------------------------
  // Reset values and bus codes
  // ------------------------------------------------------------------
  localparam logic                 RST_SYNC   = 1'h1;
  localparam logic                 RST_GLOBAL = 1'h0;
  localparam logic [NUM_CELLS-1:0] RST_POL    = 8'hFF;
  localparam logic [NUM_CELLS-1:0] RST_LOCAL  = 8'h00;
  localparam logic [NUM_CELLS-1:0] RST_CELLS  = 8'h00;
  localparam logic [NUM_PINS-1:0]  RST_PINS   = 10'h200;  // OE pin idle high
  // Signature default: value is arbitrary
  localparam logic [DATA_W-1:0]    SIG_DEFAULT = 32'h5A5A_0001;
  localparam logic [2:0]           HSIZE_WORD  = 3'h2;
  localparam logic                 HRESP_OKAY  = 1'h0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef logic [NUM_CELLS-1:0] mmc_cells_t;
  typedef enum logic [1:0] {
    MODE_SIMPLE,
    MODE_COMPLEX,
    MODE_REGISTERED
  } mmc_mode_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ,
    BUS_RDATA
  } mmc_bus_t;

endpackage

// ### rtl/mmc_top.sv
// Macrocell mode configuration with AHB-Lite register access
// Function
// - Three modes, simple, complex, registered; one mode for all cells.
// - Sync select and global control bits together choose the mode.
// - Per-cell polarity bit inverts or passes output in every mode.
// - Per-cell local bit picks output, input/output or input role.
// - Configuration is two global bits plus sixteen per-cell bits.
// - Registered mode: clock pin is register clock, OE pin is enable.
// - Complex mode: clock and OE pins are data via outer feedback paths.
// - Complex mode: the two outer cells give no own feedback.
// - Simple mode: each pin but the inner two reaches the array via neighbour feedback.
// - Simple mode: inner two cells are fixed outputs; their feedback carries the neighbour pin.
// - Cell registers clear at reset and accept any preload.
// - Readable signature held apart from the logic configuration.
// - Simple mode when sync select is one and global bit zero.
// - Polarity zero gives active low output, one gives active high.
// - Simple mode: local zero is output, local one dedicated input.
// - Registered cells share one clock pin and one enable pin.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module mmc_top (
  // Clock and reset
  input  wire logic                          REF_CLK,
  input  wire logic                          NRST,
  // AHB-Lite slave
  input  wire logic                          HSEL,
  input  wire logic [mmc_pkg::ADDR_W-1:0]    HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [mmc_pkg::DATA_W-1:0]    HWDATA,
  input  wire logic                          HREADY,
  output logic      [mmc_pkg::DATA_W-1:0]    HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  // Dedicated input pins
  input  wire logic                          CLK_PIN,
  input  wire logic                          OE_PIN_N,
  // Product-term array side
  input  wire logic [mmc_pkg::NUM_CELLS-1:0] ARRAY_SUM,
  input  wire logic [mmc_pkg::NUM_CELLS-1:0] ARRAY_OE,
  output logic      [mmc_pkg::NUM_CELLS-1:0] FEEDBACK,
  // Macrocell pins
  input  wire logic [mmc_pkg::NUM_CELLS-1:0] IO_IN,
  output logic      [mmc_pkg::NUM_CELLS-1:0] IO_OUT,
  output logic      [mmc_pkg::NUM_CELLS-1:0] IO_OE,
  // Status
  output logic      [1:0]                    MODE
);
  import mmc_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  mmc_cfg_if         cfg ();
  mmc_mode_t         mode;
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [NUM_PINS-1:0] sync3;
  logic [NUM_PINS-1:0] pin_f;
  logic [NUM_PINS-1:0] next_pin_f;
  logic              clk_prev;
  logic              clk_rise;
  mmc_cells_t        cell_q;
  mmc_cells_t        next_cell_q;
  mmc_cells_t        out_q;
  mmc_cells_t        oe_q;
  mmc_cells_t        fb_q;
  mmc_cells_t        next_out;
  mmc_cells_t        next_oe;
  mmc_cells_t        next_fb;
  mmc_bus_t          state;
  mmc_bus_t          next_state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] rd_value;
  logic              take;
  logic              preload_wr;

  // ------------------------------------------------------------------
  // Architecture bit store
  // ------------------------------------------------------------------
  mmc_cfg_store u_store (
    .clk  (REF_CLK),
    .nrst (NRST),
    .cfg  (cfg.store)
  );

  // Mode decode from the two global bits
  always_comb begin
    if (!cfg.sync_select_bit) begin
      mode = MODE_REGISTERED;
    end else if (cfg.global_arch_control_bit) begin
      mode = MODE_COMPLEX;
    end else begin
      mode = MODE_SIMPLE;
    end
  end

  assign MODE = mode;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  assign pin_raw = {OE_PIN_N, CLK_PIN, IO_IN};

  // A change counts once the second and third stages agree
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      next_pin_f[k] = (sync2[k] == sync3[k]) ? sync3[k] : pin_f[k];
    end
  end

  // Three-stage chain, filtered level and clock pin history
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1    <= RST_PINS;
      sync2    <= RST_PINS;
      sync3    <= RST_PINS;
      pin_f    <= RST_PINS;
      clk_prev <= 1'h0;
    end else begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_f    <= next_pin_f;
      clk_prev <= pin_f[PIN_CLK];
    end
  end

  // Rising edge of the common register clock pin
  assign clk_rise = pin_f[PIN_CLK] & ~clk_prev;

  // ------------------------------------------------------------------
  // Macrocell registers
  // ------------------------------------------------------------------
  // Preload beats a clock edge; capture only in registered mode
  always_comb begin
    next_cell_q = cell_q;
    if (preload_wr) begin
      next_cell_q = HWDATA[NUM_CELLS-1:0];
    end else if (cfg.run && mode == MODE_REGISTERED && clk_rise) begin
      for (int k = 0; k < NUM_CELLS; k++) begin
        if (!cfg.local_arch_control_bit[k]) begin
          next_cell_q[k] = ARRAY_SUM[k];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cell_q <= RST_CELLS;
    end else begin
      cell_q <= next_cell_q;
    end
  end

  // ------------------------------------------------------------------
  // Per-cell output, enable and feedback routing
  // ------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    // Pin whose level this cell's feedback path carries in simple mode, for all but the outer cells
    localparam int NB = (i == CELL_LO || i == CELL_HI) ? i :
                        (i <= INNER_LO) ? i - 1 : i + 1;
    localparam bit OUTER = (i == CELL_LO || i == CELL_HI);
    localparam bit INNER = (i == INNER_LO || i == INNER_HI);
    localparam int DED   = (i == CELL_HI) ? PIN_CLK : PIN_OE;

    logic src;
    logic local_bit;

    assign local_bit = cfg.local_arch_control_bit[i];

    // Output value, enable and feedback for one cell
    always_comb begin
      src = ARRAY_SUM[i];
      if (mode == MODE_REGISTERED && !local_bit) begin
        src = cell_q[i];
      end
      next_out[i] = cfg.polarity[i] ? src : ~src;
      next_oe[i]  = 1'h0;
      next_fb[i]  = pin_f[i];
      unique case (mode)
        MODE_REGISTERED: begin
          if (!local_bit) begin
            next_oe[i] = ~pin_f[PIN_OE];
            next_fb[i] = cell_q[i];
          end else begin
            next_oe[i] = ARRAY_OE[i];
          end
        end
        MODE_COMPLEX: begin
          next_oe[i] = local_bit ? ARRAY_OE[i] : 1'h1;
          if (OUTER) begin
            next_fb[i] = pin_f[DED];
          end
        end
        MODE_SIMPLE: begin
          if (INNER) begin
            next_oe[i] = 1'h1;
            next_fb[i] = 1'h0;
          end else begin
            next_oe[i] = ~local_bit;
            next_fb[i] = OUTER ? pin_f[DED] : pin_f[NB];
          end
          if (INNER) begin
            next_fb[i] = pin_f[NB];
          end
        end
        default: begin
          next_oe[i] = 1'h0;
        end
      endcase
      if (!cfg.run) begin
        next_oe[i] = 1'h0;
      end
    end
  end

  // Registered pin and array drive
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      out_q <= RST_CELLS;
      oe_q  <= RST_CELLS;
      fb_q  <= RST_CELLS;
    end else begin
      out_q <= next_out;
      oe_q  <= next_oe;
      fb_q  <= next_fb;
    end
  end

  assign IO_OUT   = out_q;
  assign IO_OE    = oe_q;
  assign FEEDBACK = fb_q;

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  assign take = HSEL & HTRANS[HTRANS_ACT_BIT] & HREADY &
                (HSIZE == HSIZE_WORD);

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_value = '0;
    unique case (addr)
      OFS_ARCH: begin
        rd_value[ARCH_SYNC_BIT]   = cfg.sync_select_bit;
        rd_value[ARCH_GLOBAL_BIT] = cfg.global_arch_control_bit;
      end
      OFS_POL:     rd_value[NUM_CELLS-1:0] = cfg.polarity;
      OFS_LOCAL:   rd_value[NUM_CELLS-1:0] = cfg.local_arch_control_bit;
      OFS_CTRL:    rd_value[CTRL_RUN_BIT]  = cfg.run;
      OFS_STATUS: begin
        rd_value[STAT_MODE_LSB +: 2]           = mode;
        rd_value[STAT_RUN_BIT]                 = cfg.run;
        rd_value[STAT_CELLS_LSB +: NUM_CELLS]  = cell_q;
      end
      OFS_SIG:     rd_value = cfg.signature;
      OFS_PRELOAD: rd_value[NUM_CELLS-1:0] = cell_q;
      OFS_PINS: begin
        rd_value[NUM_CELLS-1:0]             = out_q;
        rd_value[PINS_OE_LSB +: NUM_CELLS]  = oe_q;
        rd_value[PINS_FB_LSB +: NUM_CELLS]  = fb_q;
      end
      default:     rd_value = '0;
    endcase
  end

  // Bus phases, write strobes and read data
  always_comb begin
    next_state   = state;
    next_addr    = addr;
    next_rdata   = rdata;
    cfg.wr_arch  = 1'h0;
    cfg.wr_pol   = 1'h0;
    cfg.wr_local = 1'h0;
    cfg.wr_sig   = 1'h0;
    cfg.wr_run   = 1'h0;
    preload_wr   = 1'h0;
    cfg.wdata    = HWDATA;
    if (state == BUS_WRITE) begin
      unique case (addr)
        OFS_ARCH:    cfg.wr_arch  = 1'h1;
        OFS_POL:     cfg.wr_pol   = 1'h1;
        OFS_LOCAL:   cfg.wr_local = 1'h1;
        OFS_CTRL:    cfg.wr_run   = HWDATA[CTRL_RUN_BIT];
        OFS_SIG:     cfg.wr_sig   = 1'h1;
        OFS_PRELOAD: preload_wr   = 1'h1;
        default:     preload_wr   = 1'h0;
      endcase
    end
    if (state == BUS_READ) begin
      next_rdata = rd_value;
      next_state = BUS_RDATA;
    end else if (take) begin
      next_addr  = HADDR;
      next_state = HWRITE ? BUS_WRITE : BUS_READ;
    end else begin
      next_state = BUS_IDLE;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= BUS_IDLE;
      addr  <= OFS_ARCH;
      rdata <= '0;
    end else begin
      state <= next_state;
      addr  <= next_addr;
      rdata <= next_rdata;
    end
  end

  // One wait state on reads, writes complete at once
  assign HREADYOUT = (state != BUS_READ);
  assign HRDATA    = rdata;
  assign HRESP     = HRESP_OKAY;

endmodule

// ### verification/mmc_tool_model.sv
// Configuration tool model choosing the global architecture bits
`timescale 1ns/1ps
module mmc_tool_model (
  // Usage of the user design
  input  wire logic use_reg,
  input  wire logic use_pt_oe,
  // Chosen global bits
  output logic      sync_select_bit,
  output logic      global_arch_control_bit
);
  // Registers force registered, enables force complex, else simple
  always_comb begin
    sync_select_bit         = !use_reg;
    global_arch_control_bit = use_pt_oe && !use_reg;
  end
endmodule

// ### verification/mmc_top_properties.sv
// Port assertions for the macrocell mode configuration block
`timescale 1ns/1ps
module mmc_top_properties (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       NRST,
  // Register bus
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  // Pins
  input wire logic       CLK_PIN,
  input wire logic       OE_PIN_N,
  input wire logic [7:0] IO_IN,
  input wire logic [7:0] IO_OUT,
  input wire logic [7:0] IO_OE,
  input wire logic [7:0] FEEDBACK,
  input wire logic [1:0] MODE
);
  import mmc_pkg::*;

  logic [9:0] pin_q;
  logic [9:0] next_pin_q;
  logic [2:0] quiet;
  logic [2:0] next_quiet;
  logic [1:0] mode_q;
  logic [1:0] calm;
  logic [1:0] next_calm;
  logic       ok;
  logic       take;

  // ----------------------------------------------------------------
  // Settle counters: pins and mode unchanged for several samples
  // ----------------------------------------------------------------
  always_comb begin
    next_pin_q = {CLK_PIN, OE_PIN_N, IO_IN};
    next_quiet = (next_pin_q != pin_q) ? 3'h0
               : quiet + {2'h0, quiet != 3'h7};
    next_calm  = (MODE != mode_q) ? 2'h0 : calm + {1'h0, calm != 2'h3};
  end

  // Register the counters
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_q  <= 10'h000;
      quiet  <= 3'h0;
      mode_q <= 2'h0;
      calm   <= 2'h0;
    end else begin
      pin_q  <= next_pin_q;
      quiet  <= next_quiet;
      mode_q <= MODE;
      calm   <= next_calm;
    end
  end

  // Filtered pins have surely reached the feedback outputs
  assign ok   = (next_quiet == 3'h7) && (next_calm >= 2'h2);
  assign take = HSEL && HTRANS[1] && HREADY && (HSIZE == HSIZE_WORD);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_mode_legal: assert property (MODE != 2'h3)
    else $error("mode code out of range");
  a_reset_clean: assert property ($rose(NRST) |->
      IO_OUT == 8'h00 && IO_OE == 8'h00 && FEEDBACK == 8'h00 && MODE == 2'h0)
    else $error("outputs not clear after reset");
  a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait not exactly one cycle");
  a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  a_resp_okay: assert property (HRESP == HRESP_OKAY)
    else $error("response not okay");
  a_inner_oe: assert property (MODE == MODE_SIMPLE && calm == 2'h3
      |-> IO_OE[INNER_LO] == |IO_OE && IO_OE[INNER_HI] == |IO_OE)
    else $error("inner cells not fixed outputs");
  a_mode_frozen: assert property (|IO_OE |=> $stable(MODE))
    else $error("mode changed while running");
  a_simple_fb: assert property (MODE == MODE_SIMPLE && ok |->
      FEEDBACK == {CLK_PIN, IO_IN[7:5], IO_IN[2:0], OE_PIN_N})
    else $error("simple feedback routing wrong");
  a_complex_fb: assert property (MODE == MODE_COMPLEX && ok |->
      FEEDBACK == {CLK_PIN, IO_IN[6:1], OE_PIN_N})
    else $error("complex feedback routing wrong");

  // Main scenarios reached
  c_simple: cover property (MODE == MODE_SIMPLE && |IO_OE);
  c_complex: cover property (MODE == MODE_COMPLEX && |IO_OE);
  c_registered: cover property (MODE == MODE_REGISTERED && |IO_OE);
endmodule

bind mmc_top mmc_top_properties u_props (
  .REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLK_PIN(CLK_PIN),
  .OE_PIN_N(OE_PIN_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
  .FEEDBACK(FEEDBACK), .MODE(MODE)
);

// ### verification/test_mmc_top.sv
// Self-checking testbench for the macrocell mode configuration block
`timescale 1ns/1ps
module test_mmc_top;
  import mmc_pkg::*;

  // One configuration case and the port values it should give
  typedef struct {
    logic [1:0] arch;
    logic [7:0] pol;
    logic [7:0] loc;
    logic [7:0] sum;
    logic [7:0] aoe;
    logic [7:0] pins;
    logic       ck;
    logic       oen;
    logic [1:0] mode;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] fb;
  } mmc_row_t;

  logic        REF_CLK   = 1'b0;
  logic        NRST      = 1'b0;
  logic        HSEL      = 1'b0;
  logic [7:0]  HADDR     = 8'h00;
  logic [1:0]  HTRANS    = 2'h0;
  logic        HWRITE    = 1'b0;
  logic [2:0]  HSIZE     = 3'h2;
  logic [31:0] HWDATA    = 32'h0;
  logic        CLK_PIN   = 1'b0;
  logic        OE_PIN_N  = 1'b1;
  logic [7:0]  ARRAY_SUM = 8'h00;
  logic [7:0]  ARRAY_OE  = 8'h00;
  logic [7:0]  IO_IN     = 8'h00;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic [7:0]  FEEDBACK;
  logic [7:0]  IO_OUT;
  logic [7:0]  IO_OE;
  logic [1:0]  MODE;
  logic        use_reg   = 1'b0;
  logic        use_pt_oe = 1'b0;
  logic        tool_sync;
  logic        tool_glob;
  logic [31:0] junk;
  int          num_errors = 0;
  int          cmp_count  = 0;

  // Simple, complex, registered with pin inputs, registered with cells
  mmc_row_t rows [4] = '{
    '{2'h1, 8'hF0, 8'h89, 8'hA5, 8'h0F, 8'h3C, 1'b1, 1'b0,
      2'h0, 8'hAA, 8'h7E, 8'h98},
    '{2'h3, 8'h0F, 8'h0F, 8'h3C, 8'h05, 8'h5A, 1'b0, 1'b1,
      2'h1, 8'hCC, 8'hF5, 8'h5B},
    '{2'h0, 8'h00, 8'hFF, 8'h81, 8'h3C, 8'hC3, 1'b0, 1'b1,
      2'h2, 8'h7E, 8'h3C, 8'hC3},
    '{2'h2, 8'hAA, 8'h00, 8'h00, 8'h00, 8'hFF, 1'b0, 1'b0,
      2'h2, 8'h55, 8'hFF, 8'h00}};
  logic [7:0]  raddr [9] = '{OFS_ARCH, OFS_POL, OFS_LOCAL, OFS_CTRL,
    OFS_STATUS, OFS_SIG, OFS_PRELOAD, OFS_PINS, 8'h20};
  // Pin word: simple mode passes sum 8'h0F, feedback of pins left driven
  logic [31:0] rexp [9] = '{{30'h0, RST_GLOBAL, RST_SYNC}, {24'h0, RST_POL},
    {24'h0, RST_LOCAL}, 32'h0, 32'h0, SIG_DEFAULT, {24'h0, RST_CELLS},
    32'h00FE_000F, 32'h0};

  // ----------------------------------------------------------------
  // Design and tool model
  // ----------------------------------------------------------------
  mmc_top uut (
    .REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .CLK_PIN(CLK_PIN), .OE_PIN_N(OE_PIN_N),
    .ARRAY_SUM(ARRAY_SUM), .ARRAY_OE(ARRAY_OE), .FEEDBACK(FEEDBACK),
    .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .MODE(MODE));
  mmc_tool_model u_tool (.use_reg(use_reg), .use_pt_oe(use_pt_oe),
    .sync_select_bit(tool_sync), .global_arch_control_bit(tool_glob));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait for ready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
  endtask

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    HSEL   <= 1'b1;
    HADDR  <= a;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HSIZE  <= HSIZE_WORD;
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= wd;
    wait_rdy();
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, junk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic rst;
    NRST <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    NRST <= 1'b1;
  endtask

  // Configure, start, then compare the pin side
  task automatic run_row(input mmc_row_t r);
    rst();
    ARRAY_SUM <= r.sum;
    ARRAY_OE  <= r.aoe;
    IO_IN     <= r.pins;
    CLK_PIN   <= r.ck;
    OE_PIN_N  <= r.oen;
    wr(OFS_ARCH, {30'h0, r.arch});
    wr(OFS_POL, {24'h0, r.pol});
    wr(OFS_LOCAL, {24'h0, r.loc});
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_STATUS, {29'h1, r.mode});
    repeat (8) @(posedge REF_CLK);
    chk({30'h0, MODE}, {30'h0, r.mode});
    chk({24'h0, IO_OUT}, {24'h0, r.out});
    chk({24'h0, IO_OE}, {24'h0, r.oe});
    chk({24'h0, FEEDBACK}, {24'h0, r.fb});
  endtask

  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end

  initial begin
    repeat (3000) @(posedge REF_CLK);
    num_errors++;
    summarize();
  end

  initial begin
    foreach (rows[i]) run_row(rows[i]);
    // Running: bits frozen, preload and clock capture on the cells
    wr(OFS_ARCH, 32'h1);
    rdc(OFS_ARCH, 32'h2);
    wr(OFS_SIG, 32'h1234_5678);
    rdc(OFS_SIG, SIG_DEFAULT);
    wr(OFS_PRELOAD, 32'h3C);
    rdc(OFS_PRELOAD, 32'h3C);
    repeat (8) @(posedge REF_CLK);
    chk({24'h0, IO_OUT}, 32'h69);
    ARRAY_SUM <= 8'h0F;
    CLK_PIN   <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    rdc(OFS_STATUS, 32'h0000_0F06);
    chk({24'h0, IO_OUT}, 32'h5A);
    // Reset values, unmapped place, signature while stopped
    rst();
    foreach (raddr[i]) rdc(raddr[i], rexp[i]);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0);
    wr(OFS_SIG, 32'h1234_5678);
    rdc(OFS_SIG, 32'h1234_5678);
    // Tool picks the mode from register and enable usage
    for (int k = 0; k < 3; k++) begin
      rst();
      use_reg   <= (k == 0);
      use_pt_oe <= (k == 1);
      @(posedge REF_CLK);
      wr(OFS_ARCH, {30'h0, tool_glob, tool_sync});
      rdc(OFS_STATUS, 32'(2 - k));
    end
    summarize();
  end
endmodule
